// ### common/cft_pkg.sv
/*
  Shared constants, option tables and carrier types for the cell fault
  sequencer. Assumes a single 50 MHz core clock; all timing is counted on it.
*/
package cft_pkg;

  localparam int CLK_MHZ = 50;
  localparam int CNT_W = 28;
  localparam int N_FLT = 5;

  // timer slot of each fault
  localparam int IDX_OVP = 0;
  localparam int IDX_UVP = 1;
  localparam int IDX_DOC = 2;
  localparam int IDX_SCC = 3;
  localparam int IDX_COC = 4;

  // delay options in microseconds, selected by a two-bit factory code; the short-circuit and recovery delays are fixed
  localparam int OVP_US [4] = '{250000, 1000000, 1250000, 4500000};
  localparam int UVP_US [4] = '{20000, 96000, 125000, 144000};
  localparam int OCD_US [4] = '{8000, 16000, 20000, 48000};
  localparam int OCC_US [4] = '{4000, 6000, 8000, 16000};
  localparam int SCC_US = 250;
  localparam int REC_US = 1000;

  // threshold ranges in millivolts
  localparam int OVP_MIN_MV = 3850;
  localparam int OVP_MAX_MV = 4600;
  localparam int UVP_MIN_MV = 2000;
  localparam int UVP_MAX_MV = 2800;
  localparam int CELL_STEP_MV = 50;
  localparam int OCD_MIN_MV = 90;
  localparam int OCD_MAX_MV = 200;
  localparam int OCC_MIN_MV = 45;
  localparam int OCC_MAX_MV = 155;
  localparam int OC_STEP_MV = 5;
  localparam int ZV_START_MV = 1700;
  localparam int ZV_INH_MV = 750;

  localparam int OVP_CODE_W = 4;
  localparam int UVP_CODE_W = 5;
  localparam int OC_CODE_W = 5;
  localparam int SCC_CODE_W = 2;

  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_EVENT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h08;
  localparam int CFG_UVP_LSB = 4;
  localparam int CFG_OCD_LSB = 9;
  localparam int CFG_OCC_LSB = 14;
  localparam int CFG_SCC_LSB = 19;

  typedef struct packed {
    logic bat_above_ovp;
    logic bat_below_ovp_rel;
    logic bat_below_uvp;
    logic bat_above_uvp_rel;
    logic vm_above_ocd;
    logic vm_above_scc;
    logic vm_below_occ;
    logic vm_occ_released;
    logic load_released;
    logic charger_below_neg;
    logic charger_above_zv_start;
    logic bat_below_zv_inhibit;
  } cft_cmp_s;

  typedef struct packed {
    logic charge_overcurrent_fault;
    logic load_short_fault;
    logic discharge_overcurrent_fault;
    logic overdischarge_fault;
    logic overcharge_fault;
  } cft_flt_s;

  function automatic logic [CNT_W-1:0] us_to_cyc(input int us);
    int c;
    c = us * CLK_MHZ;
    if (c < 1) begin
      c = 1;
    end
    return CNT_W'(c);
  endfunction : us_to_cyc

  function automatic int mv_code(input int mv, input int base, input int step);
    return (mv - base) / step;
  endfunction : mv_code

endpackage : cft_pkg

// ### src/cft_delay_timer.sv
/*
  Restartable delay timer: counts while run is high, restarts from zero the
  moment run drops, flags the expiry cycle. Run comes from same-clock logic.
*/
`timescale 1ns/1ps
module cft_delay_timer #(
  parameter logic [cft_pkg::CNT_W-1:0] LIMIT = 28'h0000001
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic run_in,
  output logic done_out
);

  logic [cft_pkg::CNT_W-1:0] cnt_r;
  logic [cft_pkg::CNT_W-1:0] cnt_nxt;
  wire at_limit = (cnt_r == (LIMIT - cft_pkg::CNT_W'(1)));

  // saturate one below the limit so a held run cannot wrap; done stays high until run drops
  assign cnt_nxt = !run_in ? '0 : (at_limit ? cnt_r : cnt_r + cft_pkg::CNT_W'(1));
  assign done_out = run_in & at_limit;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r <= '0;
    end else if (ce_in) begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : cft_delay_timer

// ### src/cft_fault_seq.sv
/*
  Digital fault sequencer of a single-cell protector: times comparator faults,
  drives the charge and discharge FET gates, runs recovery timing.
  Assumes comparator results arrive asynchronously, factory options are fixed
  through parameters, and a simple strobe register port on the core clock.
*/
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
module cft_fault_seq #(
  parameter logic [1:0] OVP_DLY_SEL = 2'h0,
  parameter logic [1:0] UVP_DLY_SEL = 2'h0,
  parameter logic [1:0] OCD_DLY_SEL = 2'h0,
  parameter logic [1:0] OCC_DLY_SEL = 2'h0,
  parameter logic [cft_pkg::CNT_W-1:0] OVP_DLY_CYC =
    cft_pkg::us_to_cyc(cft_pkg::OVP_US[OVP_DLY_SEL]),
  parameter logic [cft_pkg::CNT_W-1:0] UVP_DLY_CYC =
    cft_pkg::us_to_cyc(cft_pkg::UVP_US[UVP_DLY_SEL]),
  parameter logic [cft_pkg::CNT_W-1:0] OCD_DLY_CYC =
    cft_pkg::us_to_cyc(cft_pkg::OCD_US[OCD_DLY_SEL]),
  parameter logic [cft_pkg::CNT_W-1:0] OCC_DLY_CYC =
    cft_pkg::us_to_cyc(cft_pkg::OCC_US[OCC_DLY_SEL]),
  parameter logic [cft_pkg::CNT_W-1:0] SCC_DLY_CYC =
    cft_pkg::us_to_cyc(cft_pkg::SCC_US),
  parameter logic [cft_pkg::CNT_W-1:0] REC_DLY_CYC =
    cft_pkg::us_to_cyc(cft_pkg::REC_US),
  parameter int OVP_MV = cft_pkg::OVP_MIN_MV,
  parameter int UVP_MV = cft_pkg::UVP_MIN_MV,
  parameter int OCD_MV = cft_pkg::OCD_MIN_MV,
  parameter int OCC_MV = cft_pkg::OCC_MIN_MV,
  parameter logic [cft_pkg::SCC_CODE_W-1:0] SCC_SEL = 2'h0,
  parameter logic ZV_ALLOW = 1'b1
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire cft_pkg::cft_cmp_s cmp_in,
  input wire logic [cft_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [cft_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [cft_pkg::DATA_W-1:0] reg_rdata_out,
  output logic charge_gate_drive_out,
  output logic discharge_gate_drive_out,
  output cft_pkg::cft_flt_s fault_out,
  output logic [cft_pkg::OVP_CODE_W-1:0] ovp_code_out,
  output logic [cft_pkg::UVP_CODE_W-1:0] uvp_code_out,
  output logic [cft_pkg::OC_CODE_W-1:0] ocd_code_out,
  output logic [cft_pkg::OC_CODE_W-1:0] occ_code_out,
  output logic [cft_pkg::SCC_CODE_W-1:0] scc_code_out
);

  localparam int N = cft_pkg::N_FLT;
  localparam int OVERCHARGE_FAULT = cft_pkg::IDX_OVP;
  localparam int OVERDISCHARGE_FAULT = cft_pkg::IDX_UVP;
  localparam int DOC = cft_pkg::IDX_DOC;
  localparam int LOAD_SHORT_FAULT = cft_pkg::IDX_SCC;
  localparam int COC = cft_pkg::IDX_COC;

  // threshold codes are elaboration constants only
  localparam logic [cft_pkg::OVP_CODE_W-1:0] OVP_CODE = cft_pkg::OVP_CODE_W'(
    cft_pkg::mv_code(OVP_MV, cft_pkg::OVP_MIN_MV, cft_pkg::CELL_STEP_MV));
  localparam logic [cft_pkg::UVP_CODE_W-1:0] UVP_CODE = cft_pkg::UVP_CODE_W'(
    cft_pkg::mv_code(UVP_MV, cft_pkg::UVP_MIN_MV, cft_pkg::CELL_STEP_MV));
  localparam logic [cft_pkg::OC_CODE_W-1:0] OCD_CODE = cft_pkg::OC_CODE_W'(
    cft_pkg::mv_code(OCD_MV, cft_pkg::OCD_MIN_MV, cft_pkg::OC_STEP_MV));
  localparam logic [cft_pkg::OC_CODE_W-1:0] OCC_CODE = cft_pkg::OC_CODE_W'(
    cft_pkg::mv_code(OCC_MV, cft_pkg::OCC_MIN_MV, cft_pkg::OC_STEP_MV));

  localparam logic [cft_pkg::CNT_W-1:0] DET_LIM [N] = '{
    OVP_DLY_CYC, UVP_DLY_CYC, OCD_DLY_CYC, SCC_DLY_CYC, OCC_DLY_CYC};

  typedef enum logic [0:0] {
    CFT_GATE_OFF = 1'b0,
    CFT_GATE_ON = 1'b1
  } cft_gate_e;

  // two-stage synchroniser; only stage two is read
  cft_pkg::cft_cmp_s sync1_r;
  cft_pkg::cft_cmp_s cmp_r;

  cft_pkg::cft_flt_s flt_r;
  cft_pkg::cft_flt_s flt_nxt;
  cft_pkg::cft_flt_s evt_r;
  cft_pkg::cft_flt_s evt_nxt;
  cft_gate_e chg_gate_r;
  cft_gate_e chg_gate_nxt;
  cft_gate_e dsg_gate_r;
  cft_gate_e dsg_gate_nxt;
  logic [cft_pkg::DATA_W-1:0] rdata_r;
  logic [cft_pkg::DATA_W-1:0] rdata_nxt;

  logic [N-1:0] det_run;
  logic [N-1:0] det_done;
  logic [N-1:0] rec_run;
  logic [N-1:0] rec_done;
  logic [N-1:0] flt_vec;
  logic [N-1:0] set_vec;
  logic [N-1:0] clr_vec;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sync1_r <= '0;
      cmp_r <= '0;
    end else if (ce_in) begin
      sync1_r <= cmp_in;
      cmp_r <= sync1_r;
    end
  end

  assign flt_vec = flt_r;

  // one detection and one recovery timer per fault
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_tmr
      cft_delay_timer #(
        .LIMIT(DET_LIM[gi])
      ) u_det (
        .clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .run_in(det_run[gi]),
        .done_out(det_done[gi])
      );
      cft_delay_timer #(
        .LIMIT(REC_DLY_CYC)
      ) u_rec (
        .clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .run_in(rec_run[gi]),
        .done_out(rec_done[gi])
      );
    end
  endgenerate

  // charger on the pack pulls the sense node below the charge threshold
  wire charger_on = !cmp_r.vm_occ_released;
  wire load_on = cmp_r.vm_above_ocd;
  wire dsg_faulted = flt_r.overdischarge_fault | flt_r.discharge_overcurrent_fault |
    flt_r.load_short_fault;

  // overcharge: detection and release
  wire ovp_det = cmp_r.bat_above_ovp;
  assign det_run[OVERCHARGE_FAULT] = ovp_det & !flt_r.overcharge_fault;
  // with a load, release at the detection level; a charger holds the fault
  wire ovp_rel_ok = load_on ? !ovp_det : (cmp_r.bat_below_ovp_rel & !charger_on);
  assign rec_run[OVERCHARGE_FAULT] = flt_r.overcharge_fault & ovp_rel_ok & !ovp_det;

  // overdischarge: detection and release
  wire uvp_det = cmp_r.bat_below_uvp;
  assign det_run[OVERDISCHARGE_FAULT] = uvp_det & !flt_r.overdischarge_fault;
  // strong charger releases at the detection level, else at level plus hysteresis
  wire uvp_rel_ok = cmp_r.charger_below_neg ? !uvp_det : cmp_r.bat_above_uvp_rel;
  assign rec_run[OVERDISCHARGE_FAULT] = flt_r.overdischarge_fault & uvp_rel_ok & !uvp_det;

  // discharge overcurrent and load short stay blind while the overcharge fault is set
  // and the cell sits above the overcharge level, a heavy load pulls it down first
  wire oc_blind = flt_r.overcharge_fault & ovp_det;
  wire doc_det = cmp_r.vm_above_ocd & !oc_blind;
  wire scc_det = cmp_r.vm_above_scc & !oc_blind;
  assign det_run[DOC] = doc_det & !dsg_faulted;
  assign det_run[LOAD_SHORT_FAULT] = scc_det & !dsg_faulted;
  assign rec_run[DOC] = flt_r.discharge_overcurrent_fault & cmp_r.load_released &
    !cmp_r.vm_above_ocd;
  assign rec_run[LOAD_SHORT_FAULT] = flt_r.load_short_fault & cmp_r.load_released &
    !cmp_r.vm_above_scc;

  // charge overcurrent, not watched in the overdischarge state
  wire coc_det = cmp_r.vm_below_occ & !flt_r.overdischarge_fault;
  assign det_run[COC] = coc_det & !flt_r.charge_overcurrent_fault;
  assign rec_run[COC] = flt_r.charge_overcurrent_fault & cmp_r.vm_occ_released &
    !cmp_r.vm_below_occ;

  // fault flags: expiry sets, recovery expiry clears, set wins
  assign set_vec = det_done;
  assign clr_vec = rec_done;
  assign flt_nxt = cft_pkg::cft_flt_s'(set_vec | (flt_vec & ~clr_vec));

  // zero-volt charging of a depleted cell
  wire depleted = cmp_r.bat_below_zv_inhibit;
  wire zv_ok = ZV_ALLOW ? cmp_r.charger_above_zv_start : 1'b0;
  wire zv_block = depleted & !zv_ok;

  wire chg_off = flt_r.overcharge_fault | flt_r.charge_overcurrent_fault | zv_block;

  // high turns the FET on, low turns it off
  assign chg_gate_nxt = chg_off ? CFT_GATE_OFF : CFT_GATE_ON;
  assign dsg_gate_nxt = dsg_faulted ? CFT_GATE_OFF : CFT_GATE_ON;

  // sticky trip log, write one to clear; a trip in the clear cycle survives
  wire evt_wr = reg_wr_in & (reg_addr_in == cft_pkg::ADDR_EVENT);
  wire [N-1:0] evt_clr = evt_wr ? reg_wdata_in[N-1:0] : '0;
  assign evt_nxt = cft_pkg::cft_flt_s'(set_vec | (evt_r & ~evt_clr));

  // read decode
  wire [cft_pkg::DATA_W-1:0] status_word = {
    {(cft_pkg::DATA_W - N - 2){1'b0}},
    dsg_gate_r == CFT_GATE_ON,
    chg_gate_r == CFT_GATE_ON,
    flt_vec};
  wire [cft_pkg::DATA_W-1:0] event_word = {{(cft_pkg::DATA_W - N){1'b0}}, evt_r};
  wire [cft_pkg::DATA_W-1:0] config_word = {
    {(cft_pkg::DATA_W - cft_pkg::CFG_SCC_LSB - cft_pkg::SCC_CODE_W){1'b0}},
    scc_code_out,
    occ_code_out,
    ocd_code_out,
    uvp_code_out,
    ovp_code_out};
  wire sel_status = (reg_addr_in == cft_pkg::ADDR_STATUS);
  wire sel_event = (reg_addr_in == cft_pkg::ADDR_EVENT);
  wire sel_config = (reg_addr_in == cft_pkg::ADDR_CONFIG);
  // unmapped addresses read zero; of the selections only the event word has a write path, a write of one clearing its trip bits
  assign rdata_nxt = !reg_rd_in ? '0 :
    sel_status ? status_word :
    sel_event ? event_word :
    sel_config ? config_word : '0;

  // gates held off through reset, evaluated from the first enabled edge
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      flt_r <= '0;
      chg_gate_r <= CFT_GATE_OFF;
      dsg_gate_r <= CFT_GATE_OFF;
    end else if (ce_in) begin
      flt_r <= flt_nxt;
      chg_gate_r <= chg_gate_nxt;
      dsg_gate_r <= dsg_gate_nxt;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      evt_r <= '0;
      rdata_r <= '0;
    end else if (ce_in) begin
      evt_r <= evt_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // codes load constants only, so no operating input can move a threshold
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ovp_code_out <= OVP_CODE;
      uvp_code_out <= UVP_CODE;
      ocd_code_out <= OCD_CODE;
      occ_code_out <= OCC_CODE;
      scc_code_out <= SCC_SEL;
    end
  end

  assign charge_gate_drive_out = chg_gate_r;
  assign discharge_gate_drive_out = dsg_gate_r;
  assign fault_out = flt_r;
  assign reg_rdata_out = rdata_r;

endmodule : cft_fault_seq

// ### verification/cft_fet_model.sv
/*
  Model of the external charge and discharge FET pair.
  Assumes it is driven straight from the sequencer's gate outputs.
*/
`timescale 1ns/1ps
module cft_fet_model (
  input wire logic charge_gate_drive_in,
  input wire logic discharge_gate_drive_in,
  output logic charge_path_on_out,
  output logic discharge_path_on_out
);
  // logic-level fets: a high gate conducts, no turn-on delay modelled
  assign charge_path_on_out = charge_gate_drive_in;
  assign discharge_path_on_out = discharge_gate_drive_in;
endmodule : cft_fet_model

// ### verification/cft_fault_seq_assertions.sv
/*
  Port checker for the fault sequencer.
  Assumes it is bound to cft_fault_seq and shares its overcharge delay and threshold parameters.
*/
`timescale 1ns/1ps
module cft_fault_seq_assertions #(
  parameter int OVP_L = 8,
  parameter int OVP_MV = 3850
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire cft_pkg::cft_cmp_s cmp_in,
  input wire logic charge_gate_drive_out,
  input wire logic discharge_gate_drive_out,
  input wire cft_pkg::cft_flt_s fault_out,
  input wire logic [cft_pkg::OVP_CODE_W-1:0] ovp_code_out,
  input wire logic [cft_pkg::UVP_CODE_W-1:0] uvp_code_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic [7:0] ovp_run_r;
  wire logic dsg_flt = fault_out[3] | fault_out[2] | fault_out[1];
  wire logic chg_flt = fault_out[4] | fault_out[0];
  // saturating run length of the raw overcharge level
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !cmp_in.bat_above_ovp) begin
      ovp_run_r <= 8'h00;
    end else if (ce_in && ovp_run_r != 8'hFF) begin
      ovp_run_r <= ovp_run_r + 8'h01;
    end
  end
  // a frozen clock enable holds the gate, so only enabled edges are judged
  property p_ovp_gate; $rose(fault_out[0]) && ce_in |=> !charge_gate_drive_out; endproperty
  a_ovp_gate: assert property (p_ovp_gate) else $error("charge gate on after overcharge");
  property p_uvp_gate; $rose(fault_out[1]) && ce_in |=> !discharge_gate_drive_out; endproperty
  a_uvp_gate: assert property (p_uvp_gate) else $error("gate on after overdischarge");
  property p_doc_gate; $rose(fault_out[2]) && ce_in |=> !discharge_gate_drive_out; endproperty
  a_doc_gate: assert property (p_doc_gate) else $error("gate on after overcurrent");
  property p_scc_gate; $rose(fault_out[3]) && ce_in |=> !discharge_gate_drive_out; endproperty
  a_scc_gate: assert property (p_scc_gate) else $error("gate on after load short");
  property p_coc_gate; $rose(fault_out[4]) && ce_in |=> !charge_gate_drive_out; endproperty
  a_coc_gate: assert property (p_coc_gate) else $error("gate on after charge overcurrent");
  // two sync stages ahead of the timer add two enabled cycles of level
  property p_ovp_time; $rose(fault_out[0]) |-> ovp_run_r >= OVP_L + 2; endproperty
  a_ovp_time: assert property (p_ovp_time) else $error("overcharge tripped early");
  property p_coc_mask; $past(fault_out[1]) |-> !$rose(fault_out[4]); endproperty
  a_coc_mask: assert property (p_coc_mask) else $error("charge overcurrent timed");
  property p_dsg_on; discharge_gate_drive_out && $past(ce_in) |-> !$past(dsg_flt); endproperty
  a_dsg_on: assert property (p_dsg_on) else $error("discharge gate on in fault");
  property p_chg_on; charge_gate_drive_out && $past(ce_in) |-> !$past(chg_flt); endproperty
  a_chg_on: assert property (p_chg_on) else $error("charge gate on in fault");
  property p_ce_hold;
    !ce_in && !rst_in |=> $stable({charge_gate_drive_out, discharge_gate_drive_out, fault_out});
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("state moved with enable low");
  property p_codes;
    !$past(rst_in) |-> $stable({ovp_code_out, uvp_code_out})
      && ovp_code_out == (OVP_MV - cft_pkg::OVP_MIN_MV) / cft_pkg::CELL_STEP_MV;
  endproperty
  a_codes: assert property (p_codes) else $error("threshold code changed");
  property p_reset;
    disable iff (1'b0) rst_in |=> !charge_gate_drive_out && !discharge_gate_drive_out
      && fault_out == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset left state");
endmodule : cft_fault_seq_assertions
bind cft_fault_seq cft_fault_seq_assertions #(.OVP_L(OVP_DLY_CYC), .OVP_MV(OVP_MV))
  cft_fault_seq_assertions_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .cmp_in(cmp_in), .charge_gate_drive_out(charge_gate_drive_out),
  .discharge_gate_drive_out(discharge_gate_drive_out), .fault_out(fault_out),
  .ovp_code_out(ovp_code_out), .uvp_code_out(uvp_code_out));

// ### verification/cell_fault_timer_fet_control_bench.sv
/*
  Self-checking bench for the fault sequencer with shortened delays.
  Assumes the fet model, the bound checker and one 50 MHz clock.
*/
`timescale 1ns/1ps
module cell_fault_timer_fet_control_bench;
  localparam int OVP_L = 8;
  localparam int UVP_L = 6;
  localparam int OCD_L = 5;
  localparam int OCC_L = 4;
  localparam int SCC_L = 3;
  localparam int REC_L = 10;
  localparam logic [cft_pkg::CNT_W-1:0] OVP_CYC = cft_pkg::CNT_W'(OVP_L);
  localparam logic [cft_pkg::CNT_W-1:0] UVP_CYC = cft_pkg::CNT_W'(UVP_L);
  localparam logic [cft_pkg::CNT_W-1:0] OCD_CYC = cft_pkg::CNT_W'(OCD_L);
  localparam logic [cft_pkg::CNT_W-1:0] OCC_CYC = cft_pkg::CNT_W'(OCC_L);
  localparam logic [cft_pkg::CNT_W-1:0] SCC_CYC = cft_pkg::CNT_W'(SCC_L);
  localparam logic [cft_pkg::CNT_W-1:0] REC_CYC = cft_pkg::CNT_W'(REC_L);
  localparam int OVP_MV_T = 4200;
  localparam int UVP_MV_T = 2400;
  localparam int OCD_MV_T = 150;
  localparam int OCC_MV_T = 100;
  localparam logic [1:0] SCC_T = 2'h2;
  localparam logic ZV_OFF = 1'b0;
  localparam int OVC = (OVP_MV_T - cft_pkg::OVP_MIN_MV) / cft_pkg::CELL_STEP_MV;
  localparam int UVC = (UVP_MV_T - cft_pkg::UVP_MIN_MV) / cft_pkg::CELL_STEP_MV;
  localparam int ODC = (OCD_MV_T - cft_pkg::OCD_MIN_MV) / cft_pkg::OC_STEP_MV;
  localparam int OCC = (OCC_MV_T - cft_pkg::OCC_MIN_MV) / cft_pkg::OC_STEP_MV;
  localparam logic [31:0] CFG_EXP = 32'(OVC | UVC << cft_pkg::CFG_UVP_LSB |
    ODC << cft_pkg::CFG_OCD_LSB | OCC << cft_pkg::CFG_OCC_LSB | SCC_T << cft_pkg::CFG_SCC_LSB);
  typedef struct packed {
    logic [11:0] trip;
    logic [11:0] rel;
    logic [7:0] len;
    logic [4:0] flt;
    logic [1:0] gates;
  } cft_row_s;
  // trip level, release level, delay, fault bits, {charge, discharge} gates
  cft_row_s rows [6] = '{'{12'h800, 12'h410, 8'h08, 5'h01, 2'h1},
    '{12'h200, 12'h100, 8'h06, 5'h02, 2'h2}, '{12'h200, 12'h004, 8'h06, 5'h02, 2'h2},
    '{12'h080, 12'h008, 8'h05, 5'h04, 2'h2}, '{12'h040, 12'h008, 8'h03, 5'h08, 2'h2},
    '{12'h020, 12'h010, 8'h04, 5'h10, 2'h1}};
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  cft_pkg::cft_cmp_s cmp = '0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic chg;
  logic dsg;
  logic chg_on;
  logic dsg_on;
  cft_pkg::cft_flt_s flt;
  logic [3:0] ovc;
  logic [4:0] uvc;
  logic [4:0] odc;
  logic [4:0] occ_c;
  logic [1:0] sc;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  logic zv_chg;
  cft_fault_seq #(.OVP_DLY_CYC(OVP_CYC), .UVP_DLY_CYC(UVP_CYC), .OCD_DLY_CYC(OCD_CYC),
    .OCC_DLY_CYC(OCC_CYC), .SCC_DLY_CYC(SCC_CYC), .REC_DLY_CYC(REC_CYC), .OVP_MV(OVP_MV_T),
    .UVP_MV(UVP_MV_T), .OCD_MV(OCD_MV_T), .OCC_MV(OCC_MV_T), .SCC_SEL(SCC_T)) cft_fault_seq_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in), .cmp_in(cmp),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .charge_gate_drive_out(chg), .discharge_gate_drive_out(dsg),
    .fault_out(flt), .ovp_code_out(ovc), .uvp_code_out(uvc), .ocd_code_out(odc),
    .occ_code_out(occ_c), .scc_code_out(sc));
  // second copy with zero-volt charging disallowed; its long default delays never expire here
  if (!ZV_OFF) begin : g_zv_off
    cft_fault_seq #(.ZV_ALLOW(ZV_OFF)) cft_fault_seq_inst (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in), .cmp_in(cmp),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(), .charge_gate_drive_out(zv_chg), .discharge_gate_drive_out(),
      .fault_out(), .ovp_code_out(), .uvp_code_out(), .ocd_code_out(), .occ_code_out(),
      .scc_code_out());
  end
  cft_fet_model cft_fet_model_inst (.charge_gate_drive_in(chg), .discharge_gate_drive_in(dsg),
    .charge_path_on_out(chg_on), .discharge_path_on_out(dsg_on));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick
  task automatic drive(input logic [11:0] v);
    @(posedge core_clk_in);
    cmp <= v;
  endtask : drive
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge core_clk_in);
    wr <= 1'b0;
  endtask : reg_wr
  initial begin
    forever #10 core_clk_in = ~core_clk_in;
  end
  // hang guard, far above the roughly 350 cycles the run needs
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    cft_row_s r;
    repeat (4) @(posedge core_clk_in);
    rst_in <= 1'b0;
    tick(3);
    chk({chg_on, dsg_on, flt}, 7'h60);
    chk({sc, occ_c, odc, uvc, ovc}, CFG_EXP);
    chk(zv_chg, 1'b1);
    foreach (rows[i]) begin
      r = rows[i];
      drive(r.trip);
      tick(r.len + 1);
      chk(flt, 5'h00);
      tick(1);
      chk(flt, r.flt);
      tick(1);
      chk({chg_on, dsg_on}, r.gates);
      drive(r.rel);
      tick(REC_L + 6);
      chk({chg_on, dsg_on, flt}, 7'h60);
      drive(12'h000);
      tick(4);
    end
    $display("fault table done");
    drive(12'h800);
    tick(OVP_L - 3);
    drive(12'h000);
    tick(OVP_L + 4);
    chk(flt, 5'h00);
    drive(12'h800);
    tick(4);
    @(posedge core_clk_in);
    ce_in <= 1'b0;
    tick(OVP_L + 4);
    chk(flt, 5'h00);
    @(posedge core_clk_in);
    ce_in <= 1'b1;
    tick(OVP_L + 4);
    chk(flt, 5'h01);
    drive(12'h410);
    tick(REC_L + 6);
    chk({chg_on, dsg_on, flt}, 7'h60);
    $display("clock enable test done");
    drive(12'h200);
    tick(10);
    drive(12'h220);
    tick(OCC_L + 6);
    chk(flt, 5'h02);
    drive(12'h100);
    tick(REC_L + 6);
    chk({chg_on, dsg_on}, 2'h3);
    drive(12'h001);
    tick(4);
    chk(chg_on, 1'b0);
    chk(zv_chg, 1'b0);
    drive(12'h003);
    tick(4);
    chk(chg_on, 1'b1);
    chk(zv_chg, 1'b0);
    drive(12'h000);
    $display("hand cases done");
    reg_rd(8'h04, d);
    chk(d, 32'h1F);
    reg_wr(8'h04, 32'h1F);
    reg_rd(8'h04, d);
    chk(d, 32'h0);
    reg_wr(8'h08, 32'hFFFFFFFF);
    reg_rd(8'h08, d);
    chk(d, CFG_EXP);
    reg_rd(8'h0C, d);
    chk(d, 32'h0);
    reg_rd(8'h00, d);
    chk(d, 32'h60);
    $display("register test done");
    drive(12'h800);
    tick(OVP_L + 4);
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    cmp <= '0;
    tick(1);
    chk({chg_on, dsg_on, flt}, 7'h00);
    @(posedge core_clk_in);
    rst_in <= 1'b0;
    tick(3);
    chk({chg_on, dsg_on, flt}, 7'h60);
    $display("reset test done");
    end_of_test();
  end
endmodule : cell_fault_timer_fet_control_bench
